// file: include/istc_defines.vh
`ifndef ISTC_DEFINES_VH
`define ISTC_DEFINES_VH
`define ISTC_ADDR_GIE 8'h20
`define ISTC_ADDR_EIE 8'h21
`define ISTC_ADDR_TLO 8'h24
`define ISTC_ADDR_THI 8'h25
`define ISTC_ADDR_PSC 8'hff
`define ISTC_PSC_POR 8'h11
`define ISTC_PSC_WDR 8'h41
`define ISTC_BIT_RUN 0
`define ISTC_BIT_STEP 1
`define ISTC_BIT_MASK 2
`define ISTC_BIT_SUSP 3
`define ISTC_BIT_POR 4
`define ISTC_BIT_BUSRST 5
`define ISTC_BIT_WDR 6
`define ISTC_BIT_PEND 7
`define ISTC_GIE_WMASK 8'h37
`define ISTC_EIE_WMASK 8'h07
`define ISTC_CLK_MHZ 100
`define ISTC_TICK_US 1
`define ISTC_FAST_US 128
`define ISTC_SLOW_US 1024
`define ISTC_SE0_US 8
`define ISTC_WAKE_SHORT_US 128
`define ISTC_WAKE_LONG_US 96000
`define ISTC_CALL_CYC 10
`define ISTC_JMP_CYC 5
`define ISTC_VEC_BUSRST 16'h0002
`define ISTC_VEC_DAC 16'h0014
`define ISTC_VEC_GPIO 16'h0016
`endif

// file: logic/istc_sync.v
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for a bus of asynchronous levels.
module istc_sync #(
   parameter W = 2
) (
   input wire clk,
   input wire rstN,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta_q;
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_q <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: logic/istc_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "istc_defines.vh"
// Contract
// RQ1 - 12-bit free-running counter gives 128 us and 1.024 ms tick events.
// RQ2 - Low timer read returns bits 7:0 and latches bits 11:8 for high read.
// RQ3 - Counter advances once per microsecond and wraps to zero.
// RQ4 - Halt clears run and stops core until power-on or watchdog reset.
// RQ5 - Firmware always writes one into the run bit.
// RQ6 - Single step runs one instruction then clears run; firmware keeps it 0.
// RQ7 - Bit 2 shows global enable; writes ignored; instructions change it.
// RQ8 - Writing bit 3 suspends; interrupt or bus activity wakes the core.
// RQ9 - Suspend write ignored when bus activity or interrupt already pending.
// RQ10 - Bit 4 set only by power-on; selects 128 us or 96 ms wake wait.
// RQ11 - Both data lines low over 8 us sets bit 5 and bus-reset interrupt.
// RQ12 - Bit 6 set by watchdog reset after 8 ms without clears.
// RQ13 - Bit 7 shows a recognised interrupt; acknowledge clears it.
// RQ14 - Power-on reset loads status register with 00010001.
// RQ15 - Watchdog reset loads status register with 01000001.
// RQ16 - Each source gated by its enable bit in the two enable registers.
// RQ17 - Any reset clears both enable registers; writing one enables.
// RQ18 - Pending requests sampled only in last cycle of an instruction.
// RQ19 - Service clears global enable, then source latch, then calls vector.
// RQ20 - Acknowledge call pushes program counter with carry and zero flags.
// RQ21 - Return restores counter and flags and re-enables interrupts.
// RQ22 - Enable instruction may re-enable inside a routine; nesting allowed.
// RQ23 - Firmware saves and restores the accumulator in each routine.
// RQ24 - Vectors two bytes apart from 0x0002; DAC 0x0014, GPIO 0x0016.
// RQ25 - Entry latency is remaining cycles plus 10 call plus 5 jump cycles.
module istc_ctrl #(
   parameter WAKE_LONG_CYC = `ISTC_WAKE_LONG_US * `ISTC_CLK_MHZ
) (
   input wire mclk,
   input wire rstn,
   input wire wdogRst,
   input wire port_write_instr,
   input wire ioRd,
   input wire [7:0] ioAddr,
   input wire [7:0] ioWdata,
   output reg [7:0] ioRdata_q,
   input wire instrLast,
   input wire haltInstr,
   input wire irqDisableInstr,
   input wire irqEnableInstr,
   input wire irqReturnInstr,
   input wire [15:0] pcIn,
   input wire carryFlag,
   input wire zeroFlag,
   input wire [17:0] stackIn,
   input wire usbDp,
   input wire usbDm,
   input wire busActivity,
   input wire [2:0] epEvent,
   input wire dacEvent,
   input wire gpioEvent,
   output wire cpuRun,
   output wire cpuSuspended,
   output reg irqTake_q,
   output reg [15:0] irqVector_q,
   output reg [17:0] stackPush_q,
   output reg stackPushEn_q,
   output reg [15:0] pcRestore_q,
   output reg flagRestoreCarry_q,
   output reg flagRestoreZero_q,
   output reg restoreEn_q,
   output reg wakeDone_q
);
   localparam [31:0] TICK_CYC = `ISTC_TICK_US * `ISTC_CLK_MHZ;
   localparam [31:0] SE0_CYC = `ISTC_SE0_US * `ISTC_CLK_MHZ;
   localparam [31:0] SHORT_CYC = `ISTC_WAKE_SHORT_US * `ISTC_CLK_MHZ;
   localparam [31:0] LAT_CYC = `ISTC_CALL_CYC + `ISTC_JMP_CYC;
   localparam [31:0] WAKE_LONG_W = WAKE_LONG_CYC;
   localparam NSRC = 8;
   reg rstM_q, rstS_q;
   wire rstN = rstS_q;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rstM_q <= 1'b0;
         rstS_q <= 1'b0;
      end else begin
         rstM_q <= 1'b1;
         rstS_q <= rstM_q;
      end
   end
   wire [1:0] usbSync;
   istc_sync #(.W(2)) uSync (
      .clk(mclk),
      .rstN(rstN),
      .din({usbDp, usbDm}),
      .dout(usbSync)
   );
   reg wdogM_q, wdogS_q;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wdogM_q <= 1'b0;
         wdogS_q <= 1'b0;
      end else begin
         wdogM_q <= wdogRst;
         wdogS_q <= wdogM_q;
      end
   end
   // Microsecond divider and 12-bit counter.
   reg [6:0] divCnt_q;
   reg [11:0] tmr_q;
   reg [3:0] tmrHold_q;
   wire usTick = (divCnt_q == TICK_CYC[6:0] - 7'h01);
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         divCnt_q <= 7'h00;
         tmr_q <= 12'h000;
      end else if (usTick) begin
         divCnt_q <= 7'h00;
         tmr_q <= tmr_q + 12'h001; // RQ3
      end else begin
         divCnt_q <= divCnt_q + 7'h01;
      end
   end
   wire fastEvt = usTick && (tmr_q[6:0] == 7'h7f); // RQ1
   wire slowEvt = usTick && (tmr_q[9:0] == 10'h3ff); // RQ1
   // Bus reset detect: both lines low longer than the threshold.
   reg [9:0] se0Cnt_q;
   wire se0 = (usbSync == 2'b00);
   wire se0Evt = se0 && (se0Cnt_q == SE0_CYC[9:0]); // RQ11
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         se0Cnt_q <= 10'h000;
      end else if (!se0) begin
         se0Cnt_q <= 10'h000;
      end else if (se0Cnt_q != SE0_CYC[9:0] + 10'h001) begin
         se0Cnt_q <= se0Cnt_q + 10'h001;
      end
   end
   reg [7:0] gie_q, eie_q, psc_q;
   reg gEn_q;
   wire [NSRC-1:0] latched;
   wire [NSRC-1:0] srcEvt = {gpioEvent, dacEvent, epEvent,
      slowEvt, fastEvt, se0Evt};
   wire [NSRC-1:0] srcEn = {gie_q[5], gie_q[4], eie_q[2:0], gie_q[2:0]};
   wire [NSRC-1:0] active = latched & srcEn; // RQ16
   wire anyPend = |active;
   // Lowest index wins; source index maps to its vector.
   reg [2:0] sel;
   integer i;
   always @* begin
      sel = 3'd0;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
         if (active[i]) begin
            sel = i[2:0];
         end
      end
   end
   wire [15:0] selVec = (sel == 3'd6) ? `ISTC_VEC_DAC :
      (sel == 3'd7) ? `ISTC_VEC_GPIO :
      (`ISTC_VEC_BUSRST + {12'h000, sel, 1'b0}); // RQ24
   wire take = instrLast && gEn_q && anyPend && psc_q[`ISTC_BIT_RUN]; // RQ18
   wire wrPsc = port_write_instr && (ioAddr == `ISTC_ADDR_PSC);
   wire suspReq = wrPsc && ioWdata[`ISTC_BIT_SUSP] && !busActivity &&
      !anyPend; // RQ9
   reg [NSRC-1:0] clrMask;
   always @* begin
      clrMask = {NSRC{1'b0}};
      if (take) begin
         clrMask[sel] = 1'b1;
      end
   end
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : gLatch
         reg hit_q;
         always @(posedge mclk or negedge rstN) begin
            if (!rstN) begin
               hit_q <= 1'b0;
            end else if (srcEvt[g]) begin
               hit_q <= 1'b1;
            end else if (clrMask[g]) begin
               hit_q <= 1'b0; // RQ19
            end
         end
         assign latched[g] = hit_q;
      end
   endgenerate
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         gie_q <= 8'h00; // RQ17
         eie_q <= 8'h00; // RQ17
      end else if (wdogS_q) begin
         gie_q <= 8'h00; // RQ17
         eie_q <= 8'h00;
      end else if (port_write_instr && ioAddr == `ISTC_ADDR_GIE) begin
         gie_q <= ioWdata & `ISTC_GIE_WMASK;
      end else if (port_write_instr && ioAddr == `ISTC_ADDR_EIE) begin
         eie_q <= ioWdata & `ISTC_EIE_WMASK;
      end
   end
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         gEn_q <= 1'b0;
      end else if (wdogS_q || take || irqDisableInstr) begin
         gEn_q <= 1'b0; // RQ19
      end else if (irqEnableInstr || irqReturnInstr) begin
         gEn_q <= 1'b1; // RQ7 RQ21 RQ22
      end
   end
   // Wake wait after suspend; length picked by the power-on flag.
   reg [23:0] wakeCnt_q;
   wire wakeReq = psc_q[`ISTC_BIT_SUSP] && (anyPend || busActivity); // RQ8
   wire wakeEnd = (wakeCnt_q == 24'h00_0001);
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         psc_q <= `ISTC_PSC_POR; // RQ14
         wakeCnt_q <= 24'h00_0000;
         wakeDone_q <= 1'b0;
      end else if (wdogS_q) begin
         psc_q <= `ISTC_PSC_WDR; // RQ15 RQ12
         wakeCnt_q <= 24'h00_0000;
         wakeDone_q <= 1'b0;
      end else begin
         wakeDone_q <= 1'b0;
         if (wrPsc) begin
            psc_q[`ISTC_BIT_RUN] <= ioWdata[`ISTC_BIT_RUN]; // RQ5
            psc_q[`ISTC_BIT_STEP] <= ioWdata[`ISTC_BIT_STEP];
            psc_q[`ISTC_BIT_SUSP] <= suspReq; // RQ9
            psc_q[`ISTC_BIT_POR] <= ioWdata[`ISTC_BIT_POR] &
               psc_q[`ISTC_BIT_POR]; // RQ10
            psc_q[`ISTC_BIT_BUSRST] <= ioWdata[`ISTC_BIT_BUSRST];
            psc_q[`ISTC_BIT_WDR] <= ioWdata[`ISTC_BIT_WDR];
         end
         if (se0Evt) begin
            psc_q[`ISTC_BIT_BUSRST] <= 1'b1; // RQ11
         end
         if (instrLast && (haltInstr || psc_q[`ISTC_BIT_STEP])) begin
            psc_q[`ISTC_BIT_RUN] <= 1'b0; // RQ4 RQ6
         end
         if (wakeReq && wakeCnt_q == 24'h00_0000) begin
            wakeCnt_q <= psc_q[`ISTC_BIT_POR] ? WAKE_LONG_W[23:0] :
               SHORT_CYC[23:0]; // RQ10
         end else if (wakeEnd) begin
            wakeCnt_q <= 24'h00_0000;
            psc_q[`ISTC_BIT_SUSP] <= 1'b0; // RQ8
            wakeDone_q <= 1'b1;
         end else if (wakeCnt_q != 24'h00_0000) begin
            wakeCnt_q <= wakeCnt_q - 24'h00_0001;
         end
      end
   end
   assign cpuRun = psc_q[`ISTC_BIT_RUN] && !psc_q[`ISTC_BIT_SUSP];
   assign cpuSuspended = psc_q[`ISTC_BIT_SUSP];
   wire [7:0] pscView = {anyPend, psc_q[6:3], gEn_q,
      psc_q[1:0]}; // RQ7 RQ13
   // Read path and low-byte latch of the counter's upper bits.
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         ioRdata_q <= 8'h00;
         tmrHold_q <= 4'h0;
      end else if (ioRd) begin
         if (ioAddr == `ISTC_ADDR_TLO) begin
            ioRdata_q <= tmr_q[7:0]; // RQ2
            tmrHold_q <= tmr_q[11:8]; // RQ2
         end else if (ioAddr == `ISTC_ADDR_THI) begin
            ioRdata_q <= {4'h0, tmrHold_q}; // RQ2
         end else if (ioAddr == `ISTC_ADDR_GIE) begin
            ioRdata_q <= gie_q;
         end else if (ioAddr == `ISTC_ADDR_EIE) begin
            ioRdata_q <= eie_q;
         end else if (ioAddr == `ISTC_ADDR_PSC) begin
            ioRdata_q <= pscView;
         end else begin
            ioRdata_q <= 8'h00;
         end
      end
   end
   // Acknowledge outputs: vector call, stack push and return restore.
   reg [4:0] latCnt_q;
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         irqTake_q <= 1'b0;
         irqVector_q <= 16'h0000;
         stackPush_q <= 18'h0_0000;
         stackPushEn_q <= 1'b0;
         pcRestore_q <= 16'h0000;
         flagRestoreCarry_q <= 1'b0;
         flagRestoreZero_q <= 1'b0;
         restoreEn_q <= 1'b0;
         latCnt_q <= 5'h00;
      end else begin
         irqTake_q <= take;
         stackPushEn_q <= take;
         restoreEn_q <= irqReturnInstr;
         if (take) begin
            irqVector_q <= selVec; // RQ19 RQ24
            stackPush_q <= {carryFlag, zeroFlag, pcIn}; // RQ20
            latCnt_q <= LAT_CYC[4:0]; // RQ25
         end else if (latCnt_q != 5'h00) begin
            latCnt_q <= latCnt_q - 5'h01;
         end
         if (irqReturnInstr) begin
            pcRestore_q <= stackIn[15:0]; // RQ21
            flagRestoreZero_q <= stackIn[16];
            flagRestoreCarry_q <= stackIn[17];
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/istc_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module istc_asserts (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wdogRst,
   input wire logic port_write_instr,
   input wire logic ioRd,
   input wire logic [7:0] ioAddr,
   input wire logic [7:0] ioWdata,
   input wire logic [7:0] ioRdata_q,
   input wire logic instrLast,
   input wire logic irqReturnInstr,
   input wire logic [15:0] pcIn,
   input wire logic carryFlag,
   input wire logic zeroFlag,
   input wire logic [17:0] stackIn,
   input wire logic busActivity,
   input wire logic cpuRun,
   input wire logic cpuSuspended,
   input wire logic irqTake_q,
   input wire logic [15:0] irqVector_q,
   input wire logic [17:0] stackPush_q,
   input wire logic stackPushEn_q,
   input wire logic [15:0] pcRestore_q,
   input wire logic flagRestoreCarry_q,
   input wire logic flagRestoreZero_q,
   input wire logic restoreEn_q,
   input wire logic wakeDone_q
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn || wdogRst);
   a_take_at_end: assert property (irqTake_q |->
      $past(instrLast && cpuRun))
      else $error("take outside instruction end");
   a_take_once: assert property (irqTake_q |=> !irqTake_q)
      else $error("second take with interrupts off");
   a_push_state: assert property (stackPushEn_q |-> irqTake_q &&
      stackPush_q == $past({carryFlag, zeroFlag, pcIn}))
      else $error("push value wrong");
   a_vector_legal: assert property (irqTake_q |-> irqVector_q inside
      {16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c,
      16'h0014, 16'h0016})
      else $error("vector off table");
   a_return_restore: assert property (irqReturnInstr |=> restoreEn_q &&
      {flagRestoreCarry_q, flagRestoreZero_q, pcRestore_q} == $past(stackIn))
      else $error("return restore wrong");
   a_read_holds: assert property (!$past(ioRd) |-> $stable(ioRdata_q))
      else $error("read data moved without read");
   a_wake_from_susp: assert property (wakeDone_q |->
      $past(cpuSuspended))
      else $error("wake without suspend");
   a_susp_refused: assert property (port_write_instr && ioAddr == 8'hff &&
      ioWdata[3] && busActivity && !cpuSuspended |=> !cpuSuspended)
      else $error("suspend taken with activity");
endmodule
bind istc_ctrl istc_asserts chk_u (.mclk(mclk), .rstn(rstn),
   .wdogRst(wdogRst), .port_write_instr(port_write_instr), .ioRd(ioRd), .ioAddr(ioAddr),
   .ioWdata(ioWdata), .ioRdata_q(ioRdata_q), .instrLast(instrLast),
   .irqReturnInstr(irqReturnInstr), .pcIn(pcIn), .carryFlag(carryFlag),
   .zeroFlag(zeroFlag), .stackIn(stackIn), .busActivity(busActivity),
   .cpuRun(cpuRun), .cpuSuspended(cpuSuspended), .irqTake_q(irqTake_q),
   .irqVector_q(irqVector_q), .stackPush_q(stackPush_q),
   .stackPushEn_q(stackPushEn_q), .pcRestore_q(pcRestore_q),
   .flagRestoreCarry_q(flagRestoreCarry_q),
   .flagRestoreZero_q(flagRestoreZero_q), .restoreEn_q(restoreEn_q),
   .wakeDone_q(wakeDone_q));
`default_nettype wire

// file: sim/istc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// Core stand-in: four-cycle instructions while running, and a return stack.
module istc_core_model (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cpuRun,
   input wire logic stackPushEn_q,
   input wire logic [17:0] stackPush_q,
   input wire logic restoreEn_q,
   output logic instrLast,
   output var logic [15:0] pcIn,
   output logic carryFlag,
   output logic zeroFlag,
   output logic [17:0] stackIn
);
   logic [1:0] phase_q;
   logic [2:0] sp_q;
   logic [17:0] stack_q [8];
   logic [7:0] acc_q;
   logic [7:0] accSave_q [8];
   assign instrLast = cpuRun && phase_q == 2'h3;
   assign carryFlag = pcIn[0];
   assign zeroFlag = pcIn[1];
   assign stackIn = stack_q[sp_q - 3'h1];
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_q <= 2'h0;
         pcIn <= 16'h0000;
         sp_q <= 3'h0;
         acc_q <= 8'h00;
      end else begin
         phase_q <= cpuRun ? phase_q + 2'h1 : phase_q;
         // The routine saves the accumulator on entry and restores it on
         // return, since the hardware leaves it alone.
         acc_q <= restoreEn_q ? accSave_q[sp_q - 3'h1] :
            acc_q + {7'h00, instrLast};
         pcIn <= instrLast ? pcIn + 16'h0001 : pcIn;
         if (stackPushEn_q) begin
            stack_q[sp_q] <= stackPush_q;
            accSave_q[sp_q] <= acc_q;
            sp_q <= sp_q + 3'h1;
         end else if (restoreEn_q) begin
            sp_q <= sp_q - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk = 0, rstn = 0, wdogRst = 0, port_write_instr = 0, ioRd = 0, busActivity = 0;
   logic haltInstr = 0, irqDisableInstr = 0, irqEnableInstr = 0;
   logic irqReturnInstr = 0, usbDp = 1, usbDm = 0;
   logic [7:0] ioAddr = 0, ioWdata = 0, d, t0;
   logic [4:0] ev = 0;
   wire [7:0] ioRdata_q;
   wire [15:0] pcIn, irqVector_q;
   wire [17:0] stackIn, stackPush_q;
   wire instrLast, carryFlag, zeroFlag, cpuRun, cpuSuspended, irqTake_q;
   wire stackPushEn_q, restoreEn_q;
   int n_mismatch = 0, checks_done = 0, i;
   // Row: address, write data, read-back, event bits, vector low byte.
   logic [39:0] rows [7] = '{40'h20ff_3700_00, 40'h2010_1008_14,
      40'h2020_2010_16, 40'h2101_0101_08, 40'h2102_0202_0a,
      40'h21ff_0704_0c, 40'h30ff_0000_00};
   always #5 mclk = ~mclk;
   istc_ctrl #(.WAKE_LONG_CYC(50)) dut_u (.mclk(mclk), .rstn(rstn),
      .wdogRst(wdogRst), .port_write_instr(port_write_instr), .ioRd(ioRd), .ioAddr(ioAddr),
      .ioWdata(ioWdata), .ioRdata_q(ioRdata_q), .instrLast(instrLast),
      .haltInstr(haltInstr), .irqDisableInstr(irqDisableInstr),
      .irqEnableInstr(irqEnableInstr), .irqReturnInstr(irqReturnInstr),
      .pcIn(pcIn), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
      .stackIn(stackIn), .usbDp(usbDp), .usbDm(usbDm),
      .busActivity(busActivity), .epEvent(ev[2:0]), .dacEvent(ev[3]),
      .gpioEvent(ev[4]), .cpuRun(cpuRun), .cpuSuspended(cpuSuspended),
      .irqTake_q(irqTake_q), .irqVector_q(irqVector_q),
      .stackPush_q(stackPush_q), .stackPushEn_q(stackPushEn_q),
      .pcRestore_q(), .flagRestoreCarry_q(), .flagRestoreZero_q(),
      .restoreEn_q(restoreEn_q), .wakeDone_q());
   istc_core_model core_u (.mclk(mclk), .rstn(rstn), .cpuRun(cpuRun),
      .stackPushEn_q(stackPushEn_q), .stackPush_q(stackPush_q),
      .restoreEn_q(restoreEn_q), .instrLast(instrLast), .pcIn(pcIn),
      .carryFlag(carryFlag), .zeroFlag(zeroFlag), .stackIn(stackIn));
   task step;
      @(posedge mclk) #1;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      port_write_instr = 1;
      ioAddr = a;
      ioWdata = v;
      step;
      port_write_instr = 0;
      step;
   endtask
   task rd(input logic [7:0] a);
      ioRd = 1;
      ioAddr = a;
      step;
      ioRd = 0;
      d = ioRdata_q;
      step;
   endtask
   // Instruction pulse: 0 halt, 1 disable, 2 enable, 3 return.
   task pulse(input int w);
      {haltInstr, irqDisableInstr, irqEnableInstr,
         irqReturnInstr} = 4'h8 >> w;
      step;
      {haltInstr, irqDisableInstr, irqEnableInstr, irqReturnInstr} = 4'h0;
      step;
   endtask
   // Condition: 0 take seen, 1 core stopped, 2 core awake, 3 last cycle now.
   task waitOn(input int w, input int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         if ((w == 0 && irqTake_q === 1'b1) || (w == 1 && cpuRun === 1'b0)
            || (w == 2 && cpuSuspended === 1'b0)
            || (w == 3 && instrLast === 1'b1))
            return;
         step;
      end
      n_mismatch++;
      $display("MISMATCH wait%0d exp 1 got 0", w);
      summarize;
   endtask
   initial begin
      repeat (12) step;
      rstn = 1;
      repeat (3) step;
      rd(8'hff);
      chk("psc", 8'h11, d);
      rd(8'h20);
      chk("gie", 8'h00, d);
      rd(8'h24);
      t0 = d;
      repeat (998) step;
      rd(8'h24);
      chk("tlo", t0 + 8'h0a, d);
      repeat (30000) step;
      rd(8'h25);
      chk("thi held", 8'h00, d);
      rd(8'h24);
      rd(8'h25);
      chk("thi", 8'h01, d);
      $display("test reset timer done");
      for (i = 0; i < 7; i++) begin
         wr(rows[i][39:32], rows[i][31:24]);
         rd(rows[i][39:32]);
         chk("enable", rows[i][23:16], d);
         if (rows[i][15:8] != 8'h00) begin
            pulse(1);
            ev = rows[i][12:8];
            step;
            ev = 5'h00;
            rd(8'hff);
            chk("pend", 2'h2, {d[7], d[2]});
            pulse(2);
            waitOn(0, 100);
            chk("vector", {8'h00, rows[i][7:0]}, irqVector_q);
            rd(8'hff);
            chk("acked", 2'h0, {d[7], d[2]});
            pulse(3);
         end
      end
      $display("test rows done");
      wr(8'h20, 8'h02);
      pulse(2);
      waitOn(0, 13000);
      chk("tick", 16'h0004, irqVector_q);
      pulse(3);
      wr(8'h20, 8'h01);
      {usbDp, usbDm} = 2'h0;
      waitOn(0, 1500);
      chk("busrst", 16'h0002, irqVector_q);
      usbDp = 1;
      rd(8'hff);
      chk("busrst bit", 2'h3, {d[5], cpuRun});
      pulse(3);
      $display("test events done");
      wr(8'h20, 8'h00);
      busActivity = 1;
      wr(8'hff, 8'h09);
      chk("refused", 1'b0, cpuSuspended);
      busActivity = 0;
      wr(8'hff, 8'h09);
      chk("suspend", 1'b1, cpuSuspended);
      busActivity = 1;
      step;
      busActivity = 0;
      waitOn(2, 13000);
      wr(8'hff, 8'h03);
      waitOn(1, 20);
      wdogRst = 1;
      repeat (5) step;
      wdogRst = 0;
      repeat (4) step;
      rd(8'hff);
      chk("wdog psc", 8'h41, d);
      rd(8'h21);
      chk("wdog eie", 8'h00, d);
      // The halt strobe must fall on the last cycle of the instruction.
      waitOn(3, 8);
      pulse(0);
      waitOn(1, 20);
      repeat (50) step;
      chk("halted", 1'b0, cpuRun);
      $display("test core control done");
      summarize;
   end
endmodule
`default_nettype wire
